// >>> sps_top.sv
/*
  sps_top: serial peripheral port, master or slave, with register file
  on an avalon-mm slave. assumes slave-side pins are synchronous to
  mclk and that the far clock is much slower than mclk.
*/
// What this block does
// - control writable unless block disable forces reset
// - interrupt on done or fault when enabled
// - system enable claims pins, else divider halts
// - inputs forced; outputs drive only with direction
// - master: pin5 direction picks fault input or output
// - open-drain select makes pins open-drain
// - polarity bit sets idle clock level
// - phase and polarity pick the protocol
// - rate code selects e clock divide ratio
// - rate bit two adds divide-by-four, resets zero
// - status writes change no flag
// - done flag set after every byte
// - done clears: status read, then data access
// - data writes ignored until done seen
// - collision clears: status read, data access
// - fault clears: status read, control write
// - unused status bits read zero
// - only master data write starts transfer
// - reads return receive buffer; overrun loses byte
// - receive double buffered, transmit single buffered
// - bit order option; data keeps msb at 7
// - write in transfer sets collision, is discarded
// - master select low: fault, drop master, directions
// - phase zero slave: select gates shift clock
// - eight serial clock cycles per byte
module sps_top (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [9:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire sps_pkg::sps_pins_t pinIn,
  output sps_pkg::sps_pad_t pad,
  output logic irqN
);
  typedef struct packed {
    logic [1:0] rstSync;
  } sps_rst_t;

  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] opt;
    logic [3:0] dir;
    logic [7:0] misc;
    logic done;
    logic coll;
    logic fault;
    logic doneSeen;
    logic collSeen;
    logic faultSeen;
    logic [7:0] shift;
    logic [7:0] rxBuf;
    logic [3:0] bitCnt;
    sps_pkg::sps_state_t fsm;
    logic sckOut;
    logic mosiOut;
    logic sckPrev;
    logic ssPrev;
    logic inByte;
    logic [31:0] rdata;
    logic ack;
  } sps_state_all_t;

  sps_rst_t rs_r;
  logic rstN;
  sps_state_all_t st_r;
  sps_state_all_t st_nxt;
  logic tick;
  logic divRun;
  logic [7:0] idx;
  logic wrEn;
  logic rdEn;
  logic isMaster;
  logic spiOn;
  logic pol;
  logic phase;
  logic lsbFirst;
  logic inBit;
  logic outBit;
  logic sckAct;
  logic sckIdle;
  logic leadEdge;
  logic trailEdge;
  logic ssLow;
  logic [3:0] drv;
  logic [3:0] val;
  logic [7:0] stat;

  // reset release through two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rs_r <= '0;
    end else begin
      rs_r.rstSync <= {rs_r.rstSync[0], 1'b1};
    end
  end
  assign rstN = rs_r.rstSync[1];

  assign isMaster = st_r.ctl[sps_pkg::SPS_CTL_MASTER];
  assign spiOn = st_r.ctl[sps_pkg::SPS_CTL_SYS_EN];
  assign pol = st_r.ctl[sps_pkg::SPS_CTL_POL];
  assign phase = st_r.ctl[sps_pkg::SPS_CTL_PHASE];
  assign lsbFirst = st_r.opt[sps_pkg::SPS_OPT_LSB_FIRST];
  assign divRun = spiOn && isMaster &&
    (st_r.fsm == sps_pkg::SPS_LEAD || st_r.fsm == sps_pkg::SPS_TRAIL);

  sps_rate_div uDiv (
    .mclk(mclk),
    .rstN(rstN),
    .run(divRun),
    .rate({st_r.opt[sps_pkg::SPS_OPT_RATE_TWO], st_r.ctl[1:0]}),
    .tick(tick)
  );

  assign idx = avsAddress[9:2];
  // writes commit on the answering edge; read data is loaded a cycle early
  assign wrEn = avsWrite && st_r.ack && avsByteEnable[0];
  assign rdEn = avsRead && !st_r.ack;
  // one wait state: answer on the second edge of each request
  assign avsWaitRequest = (avsRead || avsWrite) && !st_r.ack;
  assign avsReadData = st_r.rdata;
  assign irqN = !(st_r.ctl[sps_pkg::SPS_CTL_IRQ_EN] &&
    !st_r.misc[sps_pkg::SPS_MISC_CPU_MASK] &&
    (st_r.done || st_r.fault));

  // slave side clock edges from synchronous pins
  assign ssLow = !pinIn.ssN;
  assign sckAct = pinIn.sck ^ pol;
  assign sckIdle = !sckAct;
  assign leadEdge = sckAct && !(st_r.sckPrev ^ pol);
  assign trailEdge = sckIdle && (st_r.sckPrev ^ pol);
  assign inBit = isMaster ? pinIn.miso : pinIn.mosi;
  assign outBit = lsbFirst ? st_r.shift[0] : st_r.shift[7];
  assign stat = {st_r.done, st_r.coll, 1'b0, st_r.fault, 4'h0};

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.sckPrev = pinIn.sck;
    st_nxt.ssPrev = pinIn.ssN;
    if (avsRead || avsWrite) begin
      st_nxt.ack = !st_r.ack;
    end
    // register reads
    if (rdEn) begin
      st_nxt.rdata = 32'h0;
      if (idx == sps_pkg::SPS_IDX_CONTROL) begin
        st_nxt.rdata[7:0] = st_r.ctl;
      end else if (idx == sps_pkg::SPS_IDX_STATUS) begin
        st_nxt.rdata[7:0] = stat;
        st_nxt.doneSeen = st_r.done;
        st_nxt.collSeen = st_r.coll;
        st_nxt.faultSeen = st_r.fault;
      end else if (idx == sps_pkg::SPS_IDX_DATA) begin
        st_nxt.rdata[7:0] = st_r.rxBuf;
      end else if (idx == sps_pkg::SPS_IDX_OPTIONS) begin
        st_nxt.rdata[7:0] = st_r.opt;
      end else if (idx == sps_pkg::SPS_IDX_PORTDIR) begin
        st_nxt.rdata[7:0] = {2'b00, st_r.dir, 2'b00};
      end else if (idx == sps_pkg::SPS_IDX_MISC) begin
        st_nxt.rdata[7:0] = st_r.misc;
      end
    end
    // data access clears seen flags; fresh sets below still win
    if ((rdEn || wrEn) && idx == sps_pkg::SPS_IDX_DATA) begin
      if (st_r.doneSeen) begin
        st_nxt.done = 1'b0;
        st_nxt.doneSeen = 1'b0;
      end
      if (st_r.collSeen) begin
        st_nxt.coll = 1'b0;
        st_nxt.collSeen = 1'b0;
      end
    end
    if (wrEn) begin
      if (idx == sps_pkg::SPS_IDX_CONTROL) begin
        if (!st_r.misc[sps_pkg::SPS_MISC_DISABLE]) begin
          st_nxt.ctl = avsWriteData[7:0];
        end
        if (st_r.faultSeen) begin
          st_nxt.fault = 1'b0;
          st_nxt.faultSeen = 1'b0;
        end
      end else if (idx == sps_pkg::SPS_IDX_OPTIONS) begin
        st_nxt.opt = avsWriteData[7:0];
      end else if (idx == sps_pkg::SPS_IDX_PORTDIR) begin
        st_nxt.dir = avsWriteData[5:2];
      end else if (idx == sps_pkg::SPS_IDX_MISC) begin
        st_nxt.misc = avsWriteData[7:0];
      end else if (idx == sps_pkg::SPS_IDX_DATA) begin
        if (st_r.done && !st_r.doneSeen) begin
          // ignored until done has been seen
        end else if (st_r.fsm != sps_pkg::SPS_IDLE || st_r.inByte) begin
          st_nxt.coll = 1'b1;
        end else begin
          st_nxt.shift = avsWriteData[7:0];
          if (isMaster && spiOn) begin
            st_nxt.fsm = sps_pkg::SPS_LEAD;
            st_nxt.bitCnt = 4'h0;
            st_nxt.mosiOut = lsbFirst ? avsWriteData[0] : avsWriteData[7];
            st_nxt.sckOut = pol;
          end
        end
      end
      // status writes fall through untouched
    end

    // byte engine
    case (st_r.fsm)
      sps_pkg::SPS_IDLE: begin
        // follow a polarity write in the same cycle, no stale idle level
        st_nxt.sckOut = st_nxt.ctl[sps_pkg::SPS_CTL_POL];
        if (spiOn && !isMaster && ssLow) begin
          st_nxt.fsm = sps_pkg::SPS_SLAVE;
          st_nxt.bitCnt = 4'h0;
          st_nxt.mosiOut = outBit;
        end
      end
      sps_pkg::SPS_LEAD: begin
        // phase 1 shifts out on the first edge
        if (tick) begin
          st_nxt.sckOut = !pol;
          st_nxt.fsm = sps_pkg::SPS_TRAIL;
          if (phase) begin
            st_nxt.mosiOut = outBit;
          end else begin
            st_nxt.shift = lsbFirst ? {inBit, st_r.shift[7:1]}
                                    : {st_r.shift[6:0], inBit};
          end
        end
      end
      sps_pkg::SPS_TRAIL: begin
        if (tick) begin
          st_nxt.sckOut = pol;
          if (phase) begin
            st_nxt.shift = lsbFirst ? {inBit, st_r.shift[7:1]}
                                    : {st_r.shift[6:0], inBit};
          end
          if (st_r.bitCnt == 4'(sps_pkg::SPS_BITS - 1)) begin
            st_nxt.fsm = sps_pkg::SPS_IDLE;
            st_nxt.done = 1'b1;
            st_nxt.doneSeen = 1'b0;
            if (!st_r.done) begin
              st_nxt.rxBuf = phase ? (lsbFirst ?
                {inBit, st_r.shift[7:1]} : {st_r.shift[6:0], inBit})
                : st_r.shift;
            end
          end else begin
            st_nxt.bitCnt = st_r.bitCnt + 4'h1;
            st_nxt.fsm = sps_pkg::SPS_LEAD;
            if (!phase) begin
              st_nxt.mosiOut = outBit;
            end
          end
        end
      end
      sps_pkg::SPS_SLAVE: begin
        st_nxt.inByte = 1'b1;
        // phase 0 shift clock is select or'd with clock
        if (pinIn.ssN && !phase) begin
          st_nxt.fsm = sps_pkg::SPS_IDLE;
          st_nxt.inByte = 1'b0;
        end else if ((phase ? trailEdge : leadEdge) && ssLow) begin
          st_nxt.shift = lsbFirst ? {inBit, st_r.shift[7:1]}
                                  : {st_r.shift[6:0], inBit};
          if (st_r.bitCnt == 4'(sps_pkg::SPS_BITS - 1)) begin
            st_nxt.done = 1'b1;
            st_nxt.doneSeen = 1'b0;
            if (!st_r.done) begin
              st_nxt.rxBuf = lsbFirst ? {inBit, st_r.shift[7:1]}
                                      : {st_r.shift[6:0], inBit};
            end
            if (phase) begin
              st_nxt.fsm = sps_pkg::SPS_IDLE;
              st_nxt.inByte = 1'b0;
            end
          end
          st_nxt.bitCnt = st_r.bitCnt + 4'h1;
        end else if ((phase ? leadEdge : trailEdge) && ssLow) begin
          st_nxt.mosiOut = outBit;
        end
      end
      default: st_nxt.fsm = sps_pkg::SPS_IDLE;
    endcase

    // fault detect with pin5 as select input
    if (spiOn && isMaster && !st_r.dir[3] && ssLow) begin
      st_nxt.fault = 1'b1;
      st_nxt.faultSeen = 1'b0;
      st_nxt.ctl[sps_pkg::SPS_CTL_MASTER] = 1'b0;
      st_nxt.dir = 4'h0;
      st_nxt.fsm = sps_pkg::SPS_IDLE;
    end
    if (!spiOn && st_r.fsm != sps_pkg::SPS_IDLE) begin
      st_nxt.fsm = sps_pkg::SPS_IDLE;
      st_nxt.inByte = 1'b0;
    end
    if (st_r.misc[sps_pkg::SPS_MISC_DISABLE]) begin
      st_nxt.ctl = sps_pkg::SPS_CTL_RESET;
      st_nxt.fsm = sps_pkg::SPS_IDLE;
      st_nxt.inByte = 1'b0;
    end
  end

  // pad order: 0 miso, 1 mosi, 2 sck, 3 select
  always_comb begin
    drv = 4'h0;
    val = 4'h0;
    if (spiOn) begin
      if (isMaster) begin
        drv = {st_r.dir[3], st_r.dir[2:1], 1'b0};
        val = {1'b1, st_r.sckOut, st_r.mosiOut, 1'b0};
      end else begin
        drv = {3'b000, st_r.dir[0] && ssLow};
        val = {3'b000, st_r.mosiOut};
      end
    end
  end

  // open-drain drives only lows
  for (genvar i = 0; i < 4; i++) begin : gPad
    assign pad.o[i] = val[i];
    assign pad.oeN[i] = !(drv[i] &&
      !(st_r.ctl[sps_pkg::SPS_CTL_OPEN_DRAIN] && val[i]));
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      st_r <= '0;
      st_r.ctl <= sps_pkg::SPS_CTL_RESET;
      st_r.opt <= sps_pkg::SPS_OPT_RESET;
      st_r.misc <= sps_pkg::SPS_MISC_RESET;
      st_r.dir <= sps_pkg::SPS_DIR_RESET;
      st_r.fsm <= sps_pkg::SPS_IDLE;
      st_r.sckPrev <= 1'b0;
      st_r.ssPrev <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// >>> sps_pkg.sv
/*
  sps_pkg: register map, field positions, reset values and carriers
  for the serial port block. assumes an 8-bit register view on a
  32-bit avalon-mm slave, one register per aligned word.
*/
package sps_pkg;
  // register indices as printed; byte address is four times these
  localparam logic [7:0] SPS_IDX_CONTROL = 8'h28;
  localparam logic [7:0] SPS_IDX_STATUS = 8'h29;
  localparam logic [7:0] SPS_IDX_DATA = 8'h2a;
  localparam logic [7:0] SPS_IDX_OPTIONS = 8'h38;
  localparam logic [7:0] SPS_IDX_PORTDIR = 8'h3c;
  localparam logic [7:0] SPS_IDX_MISC = 8'h3d;

  // control register fields
  localparam int SPS_CTL_IRQ_EN = 7;
  localparam int SPS_CTL_SYS_EN = 6;
  localparam int SPS_CTL_OPEN_DRAIN = 5;
  localparam int SPS_CTL_MASTER = 4;
  localparam int SPS_CTL_POL = 3;
  localparam int SPS_CTL_PHASE = 2;
  localparam logic [7:0] SPS_CTL_RESET = 8'h04;

  // status register fields
  localparam int SPS_STA_DONE = 7;
  localparam int SPS_STA_COLL = 6;
  localparam int SPS_STA_FAULT = 4;

  // options register fields
  localparam int SPS_OPT_LSB_FIRST = 3;
  localparam int SPS_OPT_RATE_TWO = 2;
  localparam logic [7:0] SPS_OPT_RESET = 8'h00;

  // misc register: bit0 block disable, bit1 cpu interrupt mask
  localparam int SPS_MISC_DISABLE = 0;
  localparam int SPS_MISC_CPU_MASK = 1;
  localparam logic [7:0] SPS_MISC_RESET = 8'h00;
  localparam logic [3:0] SPS_DIR_RESET = 4'h0;

  localparam int SPS_BITS = 8;

  // divide ratios for rate codes 000..111, as half periods of e clock
  localparam logic [6:0] SPS_HALF_TAB [8] =
    '{7'h01, 7'h02, 7'h08, 7'h10, 7'h04, 7'h08, 7'h20, 7'h40};

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ssN;
  } sps_pins_t;

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oeN;
  } sps_pad_t;

  typedef enum logic [3:0] {
    SPS_IDLE = 4'b0001,
    SPS_LEAD = 4'b0010,
    SPS_TRAIL = 4'b0100,
    SPS_SLAVE = 4'b1000
  } sps_state_t;
endpackage

// >>> sps_rate_div.sv
/*
  sps_rate_div: master serial clock tick generator.
  assumes run is low whenever the shifter is idle, so ticks restart
  in phase with each byte.
*/
module sps_rate_div (
  input wire logic mclk,
  input wire logic rstN,
  input wire logic run,
  input wire logic [2:0] rate,
  output logic tick
);
  typedef struct packed {
    logic [6:0] cnt;
  } sps_div_t;

  sps_div_t st_r;
  sps_div_t st_nxt;
  logic [6:0] half;

  always_comb begin
    st_nxt = st_r;
    half = sps_pkg::SPS_HALF_TAB[rate];
    tick = 1'b0;
    if (!run) begin
      st_nxt.cnt = 7'h00;
    end else if (st_r.cnt == half - 7'h01) begin
      tick = 1'b1;
      st_nxt.cnt = 7'h00;
    end else begin
      st_nxt.cnt = st_r.cnt + 7'h01;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// >>> sps_top_sva.sv
/*
  sps_top_chk: bus, flag and serial clock checks on the sps_top ports.
  assumes byte lane 0 is enabled on every access of the bench.
*/
module sps_top_chk (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [9:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitRequest,
  input wire sps_pkg::sps_pad_t pad,
  input wire logic irqN
);
  localparam logic [7:0] CTL = sps_pkg::SPS_IDX_CONTROL;
  localparam logic [7:0] DAT = sps_pkg::SPS_IDX_DATA;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [7:0] ctlSh_r;
  logic busy_r;
  logic sckQ_r;
  logic [4:0] edges_r;
  logic ack;
  logic stRd;
  logic [7:0] idx;
  assign idx = avsAddress[9:2];
  assign ack = !avsWaitRequest && (avsRead || avsWrite);
  assign stRd = ack && avsRead && idx == sps_pkg::SPS_IDX_STATUS;
  // shadow of control as written; block disable is not tracked
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctlSh_r <= sps_pkg::SPS_CTL_RESET;
      busy_r <= 1'b0;
      sckQ_r <= 1'b0;
      edges_r <= 5'h00;
    end else begin
      sckQ_r <= pad.o[2];
      if (ack && avsWrite && avsByteEnable[0] && idx == CTL)
        ctlSh_r <= avsWriteData[7:0];
      if (ack && avsWrite && idx == DAT)
        busy_r <= 1'b1;
      else if (stRd && avsReadData[7])
        busy_r <= 1'b0;
      if (ack && avsWrite && idx == DAT && !busy_r)
        edges_r <= 5'h00;
      else if (busy_r && pad.o[2] != sckQ_r)
        edges_r <= edges_r + 5'h01;
    end
  end
  sequence sReqRise;
    (avsRead || avsWrite) && !$past(avsRead || avsWrite);
  endsequence
  sequence sAnswer;
    avsWaitRequest ##1 !avsWaitRequest;
  endsequence
  AST_ANSWER: assert property (sReqRise |-> sAnswer)
    else $error("bus answer not in second cycle");
  AST_STA_ZERO: assert property (stRd |->
    avsReadData[5] == 1'b0 && avsReadData[3:0] == 4'h0)
    else $error("unused status bits not zero");
  AST_IRQ_QUIET: assert property ((stRd && !avsReadData[7] &&
    !avsReadData[4]) |-> irqN)
    else $error("interrupt without done or fault");
  AST_IRQ_MASK: assert property (!ctlSh_r[7] ##1 !ctlSh_r[7] |-> irqN)
    else $error("interrupt while enable clear");
  AST_MISO_IN: assert property ((ctlSh_r[6] && ctlSh_r[4]) |-> pad.oeN[0])
    else $error("master drives its data input");
  AST_SYSEN_OFF: assert property (($stable(ctlSh_r) && !ctlSh_r[6]) |->
    pad.oeN[2:0] == 3'h7)
    else $error("pins driven while disabled");
  AST_SCK_IDLE: assert property ((ctlSh_r[6] && ctlSh_r[4] &&
    !busy_r && !pad.oeN[2]) |-> pad.o[2] == ctlSh_r[3])
    else $error("serial clock not at idle level");
  AST_SCK_EDGES: assert property ((stRd && avsReadData[7] && busy_r) |->
    edges_r == 5'h10)
    else $error("byte not sixteen clock edges");
endmodule

bind sps_top sps_top_chk sps_top_chk_i (
  .mclk(mclk), .nrst(nrst), .avsAddress(avsAddress), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsWriteData(avsWriteData),
  .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
  .avsWaitRequest(avsWaitRequest), .pad(pad), .irqN(irqN));

// >>> sps_far_slave.sv
/*
  sps_far_slave: behavioural far slave, msb first, one byte image.
  assumes the serial clock is much slower than mclk.
*/
module sps_far_slave (
  input wire logic mclk,
  input wire logic sck,
  input wire logic mosi,
  input wire logic clock_polarity,
  input wire logic clock_phase,
  input wire logic selN,
  input wire logic [7:0] txByte,
  output logic miso,
  output logic [7:0] rxByte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sckQ = 1'b0;
  logic rel = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [2:0] nS = 3'h0;
  initial rxByte = 8'h00;
  // bit n stands until its sampling edge is seen, even at e clock / 2
  assign miso = selN ? rel : txByte[3'h7 - nS];
  always @(posedge mclk) begin
    sckQ <= sck;
    if (selN) begin // deselect restarts the byte
      nS <= 3'h0;
      rel <= ~rel; // released line shows no stale bit
    end else if (sck !== sckQ && ((sck ^ clock_polarity) ^ clock_phase)) begin
      sh <= {sh[6:0], mosi};
      nS <= nS + 3'h1; // eight clocks per byte
      if (nS == 3'h7) begin
        rxByte <= {sh[6:0], mosi};
      end
    end
  end
endmodule

// >>> test_sps_top.sv
/*
  test_sps_top: directed bench for sps_top with a far slave model.
  assumes mclk acts as the e clock and register index = address / 4.
*/
module test_sps_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CT = sps_pkg::SPS_IDX_CONTROL;
  localparam logic [7:0] ST = sps_pkg::SPS_IDX_STATUS;
  localparam logic [7:0] DT = sps_pkg::SPS_IDX_DATA;
  localparam logic [7:0] OP = sps_pkg::SPS_IDX_OPTIONS;
  localparam logic [7:0] DR = sps_pkg::SPS_IDX_PORTDIR;
  localparam logic [7:0] MI = sps_pkg::SPS_IDX_MISC;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [9:0] avsAddress = 10'h000;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h00000000;
  logic [31:0] avsReadData;
  logic avsWaitRequest;
  logic irqN;
  sps_pkg::sps_pins_t pinIn;
  sps_pkg::sps_pad_t pad;
  logic ssN = 1'b1;
  logic selN = 1'b1;
  logic clock_polarity = 1'b0;
  logic clock_phase = 1'b1;
  logic farMiso;
  logic [7:0] rxB;
  int err_total = 0;
  int checks_done = 0;
  int hiCnt = 0;
  always #5 mclk = ~mclk;
  assign pinIn = {pad.o[2], pad.o[1], farMiso, ssN};
  always @(posedge mclk) if (pad.o[2] !== clock_polarity) hiCnt <= hiCnt + 1;
  sps_top sps_top_i (.mclk(mclk), .nrst(nrst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(4'hf), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .pinIn(pinIn), .pad(pad), .irqN(irqN));
  sps_far_slave sps_far_slave_i (.mclk(mclk), .sck(pad.o[2]),
    .mosi(pad.o[1]), .clock_polarity(clock_polarity), .clock_phase(clock_phase), .selN(selN),
    .txByte(8'h96), .miso(farMiso), .rxByte(rxB));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    logic w;
    int n;
    n = 0;
    @(posedge mclk);
    avsAddress <= {idx, 2'b00};
    avsRead <= !wr;
    avsWrite <= wr;
    avsWriteData <= {24'h000000, wd};
    do begin
      @(posedge mclk);
      w = avsWaitRequest;
      rd = avsReadData[7:0];
      n++;
    end while (w !== 1'b0 && n < 40);
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    if (n >= 40) chk("bus answer", 8'h00, 8'hff);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    acc(1'b1, idx, d, x);
  endtask
  task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] x;
    acc(1'b0, idx, 8'h00, x);
    chk(nm, e, x);
  endtask
  task automatic waitIrq;
    int n;
    n = 0;
    while (irqN !== 1'b0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 3000) chk("irq wait", 8'h00, 8'hff);
  endtask
  task automatic t_reset;
    chk("pads off", 8'h0f, {4'h0, pad.oeN});
    chk("irq idle", 8'h01, {7'h0, irqN});
    rdc("control", CT, sps_pkg::SPS_CTL_RESET);
    rdc("options", OP, sps_pkg::SPS_OPT_RESET);
    rdc("unmapped", 8'h30, 8'h00);
    wr(ST, 8'hff);
    rdc("status", ST, 8'h00);
  endtask
  task automatic t_xfer;
    wr(DR, 8'h38);
    wr(CT, 8'hd5);
    selN <= 1'b0;
    @(negedge mclk);
    chk("miso input", 8'h01, {7'h0, pad.oeN[0]});
    chk("mosi drives", 8'h00, {7'h0, pad.oeN[1]});
    chk("sck idle", 8'h00, {7'h0, pad.o[2]});
    wr(DT, 8'ha5);
    wr(DT, 8'h5a);
    waitIrq();
    wr(DT, 8'h11);
    repeat (8) @(posedge mclk);
    chk("no restart", 8'h00, {7'h0, pad.o[2]});
    chk("far rx", 8'ha5, rxB);
    rdc("status set", ST, 8'hc0);
    rdc("data rx", DT, 8'h96);
    rdc("status clr", ST, 8'h00);
    chk("irq off", 8'h01, {7'h0, irqN});
  endtask
  task automatic t_order;
    selN <= 1'b1;
    wr(OP, 8'h08);
    wr(CT, 8'hfd);
    clock_polarity <= 1'b1;
    @(negedge mclk);
    chk("sck idle hi", 8'h01, {7'h0, pad.o[2]});
    chk("open drain", 8'h01, {7'h0, pad.oeN[2]});
    @(posedge mclk);
    selN <= 1'b0; // only after the polarity edge has passed
    wr(DT, 8'h01);
    waitIrq();
    wr(MI, 8'h02);
    @(negedge mclk);
    chk("irq masked", 8'h01, {7'h0, irqN});
    wr(MI, 8'h00);
    chk("far rx lsb", 8'h80, rxB);
    rdc("status", ST, 8'h80);
    rdc("data lsb", DT, 8'h69);
  endtask
  task automatic t_rates;
    logic [7:0] dv [8];
    logic [2:0] c;
    dv = '{8'h02, 8'h04, 8'h10, 8'h20, 8'h08, 8'h10, 8'h40, 8'h80};
    selN <= 1'b1;
    clock_polarity <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      c = k[2:0];
      wr(OP, {5'h00, c[2], 2'h0});
      wr(CT, {6'h35, c[1:0]});
      @(posedge mclk);
      selN <= 1'b0; // only after the polarity edge has passed
      hiCnt = 0;
      wr(DT, 8'h00);
      waitIrq();
      chk("rate", dv[k], 8'(hiCnt / 4));
      rdc("status", ST, 8'h80);
      rdc("data", DT, 8'h96);
    end
  endtask
  task automatic t_phase0;
    wr(OP, 8'h00);
    wr(CT, 8'hd1);
    clock_phase <= 1'b0;
    wr(DT, 8'h3c);
    waitIrq();
    chk("far rx ph0", 8'h3c, rxB);
    rdc("status ph0", ST, 8'h80);
    rdc("data ph0", DT, 8'h96);
    selN <= 1'b1; // select rises between bytes
  endtask
  task automatic t_fault;
    wr(OP, 8'h00);
    wr(DR, 8'h18);
    wr(CT, 8'hd4);
    ssN <= 1'b0; // select pulled low by a rival master
    waitIrq();
    ssN <= 1'b1;
    rdc("master drop", CT, 8'hc4);
    wr(CT, 8'hc4);
    rdc("fault", ST, 8'h10);
    rdc("dirs", DR, 8'h00);
    wr(CT, 8'h44);
    rdc("fault clr", ST, 8'h00);
    chk("irq off", 8'h01, {7'h0, irqN});
  endtask
  task automatic t_disable;
    wr(MI, 8'h01);
    rdc("forced", CT, sps_pkg::SPS_CTL_RESET);
    wr(CT, 8'hd5);
    rdc("locked", CT, sps_pkg::SPS_CTL_RESET);
    wr(MI, 8'h00);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_xfer();
    t_order();
    t_rates();
    t_phase0();
    t_fault();
    t_disable();
    finish_test();
  end
  // generous span: the slowest rate dominates the run
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    finish_test();
  end
endmodule
